// File: src/mre_core.sv
// Memory reference execute unit: fetch, address, indirection and execution
// Functional notes
// - Jump/modify words: opcode bits 0-4, indirect bit 5, index 6-7, displacement 8-15.
// - Index 00 page zero, 01 PC relative, 10/11 accumulator 2/3 plus signed displacement.
// - Indirect bit set runs an indirect fetch before the operation.
// - Indirect fetch reads a second address word at the computed address.
// - Bits 1-2 at 01 or 10 mean move data, run once address ready.
// - Load copies memory word into the selected accumulator.
// - Store writes the selected accumulator to memory.
// - Bits 0-2 all zero selects jump/modify group by bits 3-4.
// - Jump copies effective address to PC and continues there.
// - Subroutine jump saves PC plus one in accumulator 3, then jumps.
// - Increment memory, write back, skip next word when zero.
// - Decrement memory, write back, skip next word when zero.
// - Accumulator field codes 0-3 pick accumulators 0-3.
// - Relative mode uses the executing instruction's address as base.
// - Bit 0 set marks arithmetic/logic; function in bits 5-7.
// - Arithmetic/logic fields are decoded and handed to the ALU.
`timescale 1ns/10ps
module mre_core
    import mre_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] busAddr,
    input wire logic [15:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [15:0] busRdata,
    output mre_mem_t memReq,
    input wire logic [15:0] memRdData,
    output logic aluStrobe,
    output mre_alu_t aluFields
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_FETCH,
        ST_FETCH_WAIT,
        ST_DECODE,
        ST_IND_RD,
        ST_IND_WAIT,
        ST_EXEC,
        ST_LOAD_WAIT,
        ST_MOD_WAIT
    } mre_state_t;

    typedef struct packed {
        mre_state_t st;
        logic run;
        logic step;
        logic [15:0] pc;
        logic [15:0] ir;
        logic [15:0] ea;
        logic [3:0][15:0] acc;
        mre_mem_t mem;
        logic [15:0] rdData;
        logic aluStb;
        mre_alu_t alu;
        logic [15:0] count;
    } mre_core_t;

    mre_core_t cur;
    mre_core_t nxt;

    logic [15:0] eaComb;
    logic isAlu;
    mre_alu_t aluDec;
    logic [1:0] moveCode;
    logic [1:0] accSel;

    // field split of the instruction word
    assign moveCode = cur.ir[POS_MV_HI:POS_MV_LO];
    assign accSel = cur.ir[POS_AC_HI:POS_AC_LO];

    mre_ea_calc eaCalc (
        .indexMode(cur.ir[POS_X_HI:POS_X_LO]),
        .disp(cur.ir[POS_D_HI:POS_D_LO]),
        .pc(cur.pc),
        .accTwo(cur.acc[2]),
        .accThree(cur.acc[3]),
        .ea(eaComb)
    );

    mre_alu_fields aluSplit (
        .instr(cur.ir),
        .isAlu(isAlu),
        .fields(aluDec)
    );

    // Outputs all come straight from the state register
    assign busRdata = cur.rdData;
    assign memReq = cur.mem;
    assign aluStrobe = cur.aluStb;
    assign aluFields = cur.alu;

    // Next state: bus slave first, then the execution sequence
    always_comb begin
        logic [15:0] modVal;
        logic [15:0] rdMux;
        logic finish;
        modVal = RESET_WORD;
        rdMux = RESET_WORD;
        finish = 1'b0;
        nxt = cur;
        nxt.mem.rd = 1'b0;
        nxt.mem.wr = 1'b0;
        nxt.aluStb = 1'b0;
        nxt.rdData = RESET_WORD;

        // Register reads answer next cycle; unmapped offsets read zero
        if (busRd) begin
            if (busAddr[7:4] == REG_AC_PAGE) begin
                rdMux = cur.acc[busAddr[3:2]];
            end else begin
                case (busAddr)
                    REG_CTRL: rdMux = {14'h0000, cur.step, cur.run};
                    REG_STATUS: rdMux = {11'h000, cur.st, cur.st != ST_IDLE};
                    REG_PC: rdMux = cur.pc;
                    REG_IR: rdMux = cur.ir;
                    REG_EA: rdMux = cur.ea;
                    REG_COUNT: rdMux = cur.count;
                    default: rdMux = RESET_WORD;
                endcase
            end
            nxt.rdData = rdMux;
        end

        // PC and accumulators only take bus writes while halted, so
        // software can never tear a running instruction
        if (busWr) begin
            if (busAddr == REG_CTRL) begin
                nxt.run = busWdata[CTRL_RUN];
                nxt.step = cur.step | busWdata[CTRL_STEP];
            end else if (cur.st == ST_IDLE) begin
                if (busAddr == REG_PC) begin
                    nxt.pc = busWdata;
                end else if (busAddr[7:4] == REG_AC_PAGE) begin
                    nxt.acc[busAddr[3:2]] = busWdata;
                end
            end
        end

        unique case (cur.st)
            ST_IDLE: begin
                if (cur.run || cur.step) begin
                    // A step request arriving now stays pending: set wins over consume
                    nxt.step = busWr && (busAddr == REG_CTRL) && busWdata[CTRL_STEP];
                    nxt.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                nxt.mem.rd = 1'b1;
                nxt.mem.addr = cur.pc;
                nxt.st = ST_FETCH_WAIT;
            end
            ST_FETCH_WAIT: begin
                nxt.ir = memRdData;
                nxt.st = ST_DECODE;
            end
            ST_DECODE: begin
                if (isAlu) begin
                    nxt.alu = aluDec;
                    nxt.aluStb = 1'b1;
                    nxt.pc = cur.pc + ONE;
                    finish = 1'b1;
                end else begin
                    nxt.ea = eaComb;
                    nxt.st = cur.ir[POS_IND] ? ST_IND_RD : ST_EXEC;
                end
            end
            ST_IND_RD: begin
                nxt.mem.rd = 1'b1;
                nxt.mem.addr = cur.ea;
                nxt.st = ST_IND_WAIT;
            end
            ST_IND_WAIT: begin
                nxt.ea = memRdData;
                nxt.st = ST_EXEC;
            end
            ST_EXEC: begin
                // move data when bits 1-2 are 01 or 10
                if (moveCode == MV_LOAD) begin
                    nxt.mem.rd = 1'b1;
                    nxt.mem.addr = cur.ea;
                    nxt.st = ST_LOAD_WAIT;
                end else if (moveCode == MV_STORE) begin
                    nxt.mem.wr = 1'b1;
                    nxt.mem.addr = cur.ea;
                    nxt.mem.wdata = cur.acc[accSel];
                    nxt.pc = cur.pc + ONE;
                    finish = 1'b1;
                end else if (moveCode == MV_JMPGRP) begin
                    unique case (accSel)
                        JM_JUMP: begin
                            nxt.pc = cur.ea;
                            finish = 1'b1;
                        end
                        JM_SUBR: begin
                            nxt.acc[3] = cur.pc + ONE;
                            nxt.pc = cur.ea;
                            finish = 1'b1;
                        end
                        JM_INCSKIP, JM_DECSKIP: begin
                            nxt.mem.rd = 1'b1;
                            nxt.mem.addr = cur.ea;
                            nxt.st = ST_MOD_WAIT;
                        end
                    endcase
                end else begin
                    // Code 11 is outside this unit; step over it
                    nxt.pc = cur.pc + ONE;
                    finish = 1'b1;
                end
            end
            ST_LOAD_WAIT: begin
                nxt.acc[accSel] = memRdData;
                nxt.pc = cur.pc + ONE;
                finish = 1'b1;
            end
            ST_MOD_WAIT: begin
                modVal = (accSel == JM_INCSKIP) ? memRdData + ONE : memRdData - ONE;
                nxt.mem.wr = 1'b1;
                nxt.mem.addr = cur.ea;
                nxt.mem.wdata = modVal;
                nxt.pc = cur.pc + ((modVal == RESET_WORD) ? SKIP_STEP : ONE);
                finish = 1'b1;
            end
        endcase

        if (finish) begin
            nxt.count = cur.count + ONE;
            nxt.st = nxt.run ? ST_FETCH : ST_IDLE;
        end
    end

    // Single state register for the whole unit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
            cur.st <= ST_IDLE;
            cur.pc <= RESET_PC;
        end else begin
            cur <= nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence indAddrOut;
        cur.mem.rd && cur.mem.addr == cur.ea;
    endsequence

    sequence indLoaded;
        cur.st == ST_EXEC && cur.ea == $past(memRdData);
    endsequence

    sequence writeThenFetch;
        !cur.mem.rd ##1 (cur.mem.rd && cur.mem.addr == cur.pc);
    endsequence

    fetch_addr_a:
        assert property (cur.st == ST_FETCH |=> cur.mem.rd && cur.mem.addr == cur.pc)
        else $error("fetch not issued at program counter");

    ind_sequence_a:
        assert property (cur.st == ST_DECODE && !isAlu && cur.ir[POS_IND]
            |=> cur.st == ST_IND_RD ##1 indAddrOut ##1 indLoaded)
        else $error("indirect sequence broken");

    ind_replace_a:
        assert property (cur.st == ST_IND_WAIT |=> cur.ea == $past(memRdData))
        else $error("pointer word did not replace address");

    ea_form_a:
        assert property (cur.st == ST_DECODE && !isAlu |=> cur.ea == $past(eaComb))
        else $error("effective address not formed");

    load_acc_a:
        assert property (cur.st == ST_LOAD_WAIT
            |=> cur.acc[$past(accSel)] == $past(memRdData) && cur.pc == $past(cur.pc) + ONE)
        else $error("load did not reach accumulator");

    store_word_a:
        assert property (cur.st == ST_EXEC && moveCode == MV_STORE
            |=> cur.mem.wr && cur.mem.addr == cur.ea && cur.mem.wdata == cur.acc[accSel])
        else $error("store word wrong");

    subr_link_a:
        assert property (cur.st == ST_EXEC && moveCode == MV_JMPGRP && accSel == JM_SUBR
            |=> cur.acc[3] == $past(cur.pc) + ONE && cur.pc == $past(cur.ea))
        else $error("subroutine link wrong");

    inc_skip_a:
        assert property (cur.st == ST_MOD_WAIT && accSel == JM_INCSKIP
            && memRdData == 16'hffff
            |=> cur.mem.wr && cur.mem.wdata == RESET_WORD
            && cur.pc == $past(cur.pc) + SKIP_STEP)
        else $error("increment skip wrong");

    dec_noskip_a:
        assert property (cur.st == ST_MOD_WAIT && accSel == JM_DECSKIP
            && memRdData != ONE
            |=> cur.mem.wdata == $past(memRdData) - ONE && cur.pc == $past(cur.pc) + ONE)
        else $error("decrement result wrong");

    write_first_a:
        assert property (cur.mem.wr && cur.st == ST_FETCH |-> writeThenFetch)
        else $error("fetch overlapped a write");

    alu_handoff_a:
        assert property (cur.st == ST_DECODE && isAlu
            |=> aluStrobe && aluFields.func == $past(cur.ir[POS_FN_HI:POS_FN_LO]))
        else $error("alu fields not handed over");
endmodule

// File: include/mre_pkg.sv
// Shared constants and carrier types for the memory reference execute unit
package mre_pkg;
    localparam int WORD_W = 16;
    localparam int BUS_AW = 8;

    // Word bit 0 is the MSB, so field positions count down from 15
    localparam int POS_CLASS = 15;
    localparam int POS_MV_HI = 14;
    localparam int POS_MV_LO = 13;
    localparam int POS_AC_HI = 12;
    localparam int POS_AC_LO = 11;
    localparam int POS_IND = 10;
    localparam int POS_X_HI = 9;
    localparam int POS_X_LO = 8;
    localparam int POS_D_HI = 7;
    localparam int POS_D_LO = 0;
    localparam int POS_FN_HI = 10;
    localparam int POS_FN_LO = 8;
    localparam int POS_SH_HI = 7;
    localparam int POS_SH_LO = 6;
    localparam int POS_CY_HI = 5;
    localparam int POS_CY_LO = 4;
    localparam int POS_NL = 3;
    localparam int POS_SK_HI = 2;
    localparam int POS_SK_LO = 0;

    // Move-data codes in word bits 1-2
    localparam logic [1:0] MV_JMPGRP = 2'h0;
    localparam logic [1:0] MV_LOAD = 2'h1;
    localparam logic [1:0] MV_STORE = 2'h2;
    // Jump and modify-memory codes in word bits 3-4
    localparam logic [1:0] JM_JUMP = 2'h0;
    localparam logic [1:0] JM_SUBR = 2'h1;
    localparam logic [1:0] JM_INCSKIP = 2'h2;
    localparam logic [1:0] JM_DECSKIP = 2'h3;
    // Index modes in word bits 6-7
    localparam logic [1:0] IDX_PAGE0 = 2'h0;
    localparam logic [1:0] IDX_REL = 2'h1;
    localparam logic [1:0] IDX_AC2 = 2'h2;
    localparam logic [1:0] IDX_AC3 = 2'h3;

    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PC = 8'h08;
    localparam logic [7:0] REG_IR = 8'h0c;
    localparam logic [7:0] REG_EA = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    localparam logic [3:0] REG_AC_PAGE = 4'h2;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STEP = 1;

    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] ONE = 16'h0001;
    localparam logic [15:0] SKIP_STEP = 16'h0002;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mre_mem_t;

    typedef struct packed {
        logic [1:0] srcAcc;
        logic [1:0] dstAcc;
        logic [2:0] func;
        logic [1:0] shiftCtl;
        logic [1:0] carrySel;
        logic noLoad;
        logic [2:0] skipCond;
    } mre_alu_t;
endpackage

// File: src/mre_ea_calc.sv
// Effective address former for the four index modes
`timescale 1ns/10ps
module mre_ea_calc
    import mre_pkg::*;
(
    input wire logic [1:0] indexMode,
    input wire logic [7:0] disp,
    input wire logic [15:0] pc,
    input wire logic [15:0] accTwo,
    input wire logic [15:0] accThree,
    output logic [15:0] ea
);
    // Displacement is signed for every mode but page zero
    function automatic logic [15:0] sext(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction

    // relative base is the executing word's address
    always_comb begin
        unique case (indexMode)
            IDX_PAGE0: ea = {8'h00, disp};
            IDX_REL: ea = pc + sext(disp);
            IDX_AC2: ea = accTwo + sext(disp);
            IDX_AC3: ea = accThree + sext(disp);
        endcase
    end
endmodule

// File: src/mre_alu_fields.sv
// Field splitter for the arithmetic/logic instruction class
`timescale 1ns/10ps
module mre_alu_fields
    import mre_pkg::*;
(
    input wire logic [15:0] instr,
    output logic isAlu,
    output mre_alu_t fields
);
    assign isAlu = instr[POS_CLASS];

    always_comb begin
        fields.srcAcc = instr[POS_MV_HI:POS_MV_LO];
        fields.dstAcc = instr[POS_AC_HI:POS_AC_LO];
        fields.func = instr[POS_FN_HI:POS_FN_LO];
        fields.shiftCtl = instr[POS_SH_HI:POS_SH_LO];
        fields.carrySel = instr[POS_CY_HI:POS_CY_LO];
        fields.noLoad = instr[POS_NL];
        fields.skipCond = instr[POS_SK_HI:POS_SK_LO];
    end
endmodule

// File: tb/mre_mem_model.sv
// Behavioural main memory answering the unit's word requests
`timescale 1ns/10ps
module mre_mem_model
    import mre_pkg::*;
(
    input wire logic clk,
    input wire mre_mem_t memReq,
    output logic [15:0] memRdData
);
    logic [15:0] mem [0:65535];

    // Start from a clean image so stray reads never return unknowns
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'h0000;
        end
    end

    // Writes land at the edge ending the wr cycle
    always @(posedge clk) begin
        if (memReq.wr) begin
            mem[memReq.addr] <= memReq.wdata;
        end
    end

    // The unit takes the word in the cycle its registered rd stands, so the
    // read is combinational; outside that cycle show the inverse
    assign memRdData = memReq.rd ? mem[memReq.addr] : ~mem[memReq.addr];
endmodule

// File: tb/tb.sv
// Self-checking bench for the memory reference execute unit
`timescale 1ns/10ps
module tb
    import mre_pkg::*;
;
    logic clk;
    logic rst_n;
    logic [7:0] busAddr;
    logic [15:0] busWdata;
    logic busWr;
    logic busRd;
    logic [15:0] busRdata;
    mre_mem_t memReq;
    logic [15:0] memRdData;
    logic aluStrobe;
    mre_alu_t aluFields;
    mre_alu_t aluSeen[$];
    int failures;
    int checks;

    mre_core i_mre_core (.clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .memReq(memReq),
        .memRdData(memRdData), .aluStrobe(aluStrobe), .aluFields(aluFields));
    mre_mem_model i_mre_mem_model (.clk(clk), .memReq(memReq), .memRdData(memRdData));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Record every decoded arithmetic/logic word; the falling edge keeps clear
    // of the rising edge that launches the strobe
    always @(negedge clk) begin
        if (aluStrobe === 1'b1) begin
            aluSeen.push_back(aluFields);
        end
    end

    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge clk);
        busWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge clk);
        busRd <= 1'b0;
        #1 d = busRdata;
    endtask

    function automatic logic [15:0] enc(input logic [1:0] mv, input logic [1:0] sel,
        input logic ind, input logic [1:0] x, input logic [7:0] d);
        return {1'b0, mv, sel, ind, x, d};
    endfunction

    function automatic logic [15:0] halt_at(input logic [7:0] a);
        return enc(MV_JMPGRP, JM_JUMP, 1'b0, IDX_PAGE0, a);
    endfunction

    function automatic logic [7:0] acc_addr(input int i);
        return {REG_AC_PAGE, i[1:0], 2'b00};
    endfunction

    task automatic pm(input logic [15:0] a, input logic [15:0] v);
        i_mre_mem_model.mem[a] = v;
    endtask

    task automatic set_accs(input logic [15:0] a0, input logic [15:0] a1,
        input logic [15:0] a2, input logic [15:0] a3);
        bus_write(acc_addr(0), a0);
        bus_write(acc_addr(1), a1);
        bus_write(acc_addr(2), a2);
        bus_write(acc_addr(3), a3);
    endtask

    task automatic check_acc(input int i, input logic [15:0] exp);
        logic [15:0] d;
        bus_read(acc_addr(i), d);
        check("accumulator", exp, d);
    endtask

    // Run from start until the self-jump at stop, then halt the unit
    task automatic run_prog(input logic [15:0] start, input logic [15:0] stop);
        logic [15:0] d;
        int n;
        bus_write(REG_PC, start);
        bus_write(REG_CTRL, 16'h0001);
        d = 16'h0000;
        n = 0;
        while (d !== stop && n < 300) begin
            bus_read(REG_PC, d);
            n++;
        end
        check("program counter at stop", stop, d);
        bus_write(REG_CTRL, 16'h0000);
        d = 16'h0001;
        n = 0;
        while (d[0] !== 1'b0 && n < 50) begin
            bus_read(REG_STATUS, d);
            n++;
        end
        check("busy after stop", 16'h0000, {15'h0000, d[0]});
    endtask

    task automatic test_load_modes();
        logic [15:0] d;
        bus_read(8'h3c, d);
        check("unmapped read", 16'h0000, d);
        pm(16'h0010, enc(MV_LOAD, 2'h0, 1'b0, IDX_PAGE0, 8'h80));
        pm(16'h0011, enc(MV_LOAD, 2'h1, 1'b0, IDX_REL, 8'hff));
        pm(16'h0012, enc(MV_LOAD, 2'h3, 1'b0, IDX_AC2, 8'hfe));
        pm(16'h0013, enc(MV_LOAD, 2'h2, 1'b0, IDX_AC3, 8'h01));
        pm(16'h0014, halt_at(8'h14));
        pm(16'h0080, 16'h1111);
        pm(16'h008e, 16'h3333);
        pm(16'h3334, 16'h4444);
        set_accs(16'h0000, 16'h0000, 16'h0090, 16'h00a0);
        run_prog(16'h0010, 16'h0014);
        check_acc(0, 16'h1111);
        check_acc(1, enc(MV_LOAD, 2'h0, 1'b0, IDX_PAGE0, 8'h80));
        check_acc(3, 16'h3333);
        check_acc(2, 16'h4444);
        check("memory kept on load", 16'h1111, i_mre_mem_model.mem[16'h0080]);
    endtask

    // indirect store, then load of the same word
    task automatic test_store_indirect();
        pm(16'h0020, enc(MV_STORE, 2'h1, 1'b1, IDX_PAGE0, 8'h40));
        pm(16'h0021, enc(MV_LOAD, 2'h2, 1'b1, IDX_PAGE0, 8'h40));
        pm(16'h0022, halt_at(8'h22));
        pm(16'h0040, 16'h0500);
        pm(16'h0500, 16'h0bad);
        set_accs(16'h0000, 16'hbeef, 16'h0000, 16'h0000);
        run_prog(16'h0020, 16'h0022);
        check("stored word", 16'hbeef, i_mre_mem_model.mem[16'h0500]);
        check("pointer word", 16'h0500, i_mre_mem_model.mem[16'h0040]);
        check_acc(1, 16'hbeef);
        check_acc(2, 16'hbeef);
    endtask

    task automatic test_jumps();
        pm(16'h0030, enc(MV_JMPGRP, JM_SUBR, 1'b0, IDX_REL, 8'h05));
        pm(16'h0035, enc(MV_JMPGRP, JM_JUMP, 1'b1, IDX_PAGE0, 8'h41));
        pm(16'h0036, enc(MV_LOAD, 2'h0, 1'b0, IDX_PAGE0, 8'h80));
        pm(16'h0037, halt_at(8'h37));
        pm(16'h0041, 16'h0037);
        set_accs(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        run_prog(16'h0030, 16'h0037);
        check_acc(3, 16'h0031);
        check_acc(0, 16'h0000);
    endtask

    // modify memory with and without skip
    task automatic test_modify_skip();
        pm(16'h0050, enc(MV_JMPGRP, JM_INCSKIP, 1'b0, IDX_PAGE0, 8'h60));
        pm(16'h0051, enc(MV_LOAD, 2'h0, 1'b0, IDX_PAGE0, 8'h80));
        pm(16'h0052, enc(MV_JMPGRP, JM_DECSKIP, 1'b0, IDX_PAGE0, 8'h61));
        pm(16'h0053, enc(MV_LOAD, 2'h1, 1'b0, IDX_PAGE0, 8'h80));
        pm(16'h0054, enc(MV_JMPGRP, JM_DECSKIP, 1'b0, IDX_PAGE0, 8'h62));
        pm(16'h0055, enc(MV_LOAD, 2'h2, 1'b0, IDX_PAGE0, 8'h80));
        pm(16'h0056, enc(MV_JMPGRP, JM_INCSKIP, 1'b0, IDX_PAGE0, 8'h63));
        pm(16'h0057, halt_at(8'h57));
        pm(16'h0060, 16'hffff);
        pm(16'h0061, 16'h0002);
        pm(16'h0062, 16'h0001);
        pm(16'h0063, 16'h0005);
        set_accs(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        run_prog(16'h0050, 16'h0057);
        check("increment wrap", 16'h0000, i_mre_mem_model.mem[16'h0060]);
        check("decrement", 16'h0001, i_mre_mem_model.mem[16'h0061]);
        check("decrement to zero", 16'h0000, i_mre_mem_model.mem[16'h0062]);
        check("increment", 16'h0006, i_mre_mem_model.mem[16'h0063]);
        check_acc(0, 16'h0000);
        check_acc(1, 16'h1111);
        check_acc(2, 16'h0000);
    endtask

    // arithmetic words hand their fields out
    task automatic test_alu_fields();
        aluSeen.delete();
        pm(16'h0070, 16'hd5a5);
        pm(16'h0071, 16'hea5a);
        pm(16'h0072, halt_at(8'h72));
        run_prog(16'h0070, 16'h0072);
        check("alu word count", 16'h0002, 16'(aluSeen.size()));
        if (aluSeen.size() == 2) begin
            check("alu fields first", 16'h55a5, {1'b0, aluSeen[0]});
            check("alu fields second", 16'h6a5a, {1'b0, aluSeen[1]});
        end
    endtask

    // Single step, retired count, and PC writes refused while running
    task automatic test_step_guard();
        logic [15:0] d;
        logic [15:0] c;
        bus_read(REG_COUNT, c);
        bus_write(REG_PC, 16'h0070);
        bus_write(REG_CTRL, 16'h0002);
        repeat (12) @(posedge clk);
        bus_read(REG_PC, d);
        check("program counter after step", 16'h0071, d);
        bus_read(REG_IR, d);
        check("instruction after step", 16'hd5a5, d);
        bus_read(REG_COUNT, d);
        check("retired count after step", c + ONE, d);
        bus_read(REG_CTRL, d);
        check("control after step", 16'h0000, d);
        bus_write(REG_PC, 16'h0072);
        bus_write(REG_CTRL, 16'h0001);
        bus_write(REG_PC, 16'h0010);
        bus_read(REG_PC, d);
        check("program counter write while running", 16'h0072, d);
        bus_read(REG_EA, d);
        check("effective address of halt jump", 16'h0072, d);
        bus_write(REG_CTRL, 16'h0000);
        repeat (12) @(posedge clk);
        bus_read(REG_STATUS, d);
        check("status after halt", 16'h0000, d);
    endtask

    // Cut a hang short well past the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        logic [15:0] d;
        failures = 0;
        checks = 0;
        rst_n = 1'b0;
        busAddr = 8'h00;
        busWdata = 16'h0000;
        busWr = 1'b0;
        busRd = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        bus_read(REG_PC, d);
        check("reset program counter", RESET_PC, d);
        test_load_modes();
        test_store_indirect();
        test_jumps();
        test_modify_skip();
        test_alu_fields();
        test_step_guard();
        give_verdict();
    end
endmodule
